// >>> hdl/tpsel_pkg.sv
// Constants and types shared by the transmitter panel selection block.
package tpsel_pkg;
    localparam int          CORE_HZ  = 200_000_000;
    localparam int          CCLK_HZ  = 19_200;
    localparam int          HALF_DIV = CORE_HZ / (2 * CCLK_HZ);
    localparam int          MODE_N   = 8;
    localparam int          FREQ_W   = 24;
    localparam int          REV_W    = 16;
    localparam int          CTL_W    = 14;
    localparam logic [7:0]  A_STATE  = 8'h00;
    localparam logic [7:0]  A_PEER   = 8'h04;
    localparam logic [7:0]  A_RECALL = 8'h08;
    localparam logic [7:0]  A_REVERT = 8'h0c;
    localparam logic [7:0]  MODE_RST = 8'h01;
    localparam logic [31:0] PEER_RST = 32'h0000_0000;
    localparam int          F_MODE   = 24;
    localparam int          F_TX     = 8;
    localparam int          F_ST     = 16;
    localparam int          REV_UF   = 8;
    localparam int          REV_MODE = 12;
    localparam logic [1:0]  RESP_OK  = 2'h0;
    localparam logic [1:0]  RESP_ERR = 2'h2;

    typedef enum logic [3:0] {
        ST_NORM  = 4'h1,
        ST_CHECK = 4'h2,
        ST_IN    = 4'h4,
        ST_OUT   = 4'h8
    } tpsel_stat_e;

    typedef enum logic [2:0] {
        SH_IDLE  = 3'h1,
        SH_SHIFT = 3'h2,
        SH_STB   = 3'h4
    } tpsel_sh_e;
endpackage : tpsel_pkg

// >>> hdl/tpsel_ser_if.sv
// Handshake between the panel logic and one serial shift engine.
`timescale 1ns/100ps
interface tpsel_ser_if #(parameter int W = 8);
    logic         start;
    logic         busy;
    logic         done;
    logic [W-1:0] tx_word;
    logic [W-1:0] rx_word;
    modport ctl (output start, output tx_word, input busy, input done, input rx_word);
    modport eng (input start, input tx_word, output busy, output done, output rx_word);
endinterface : tpsel_ser_if

// >>> hdl/tpsel_div.sv
// Divider that makes the half-period enable of the serial control clock.
`timescale 1ns/100ps
module tpsel_div import tpsel_pkg::*; #(
    parameter int HALF = HALF_DIV
) (
    input  wire logic clk,
    input  wire logic rst,
    output wire logic tick
);
    localparam int            CW   = $clog2(HALF + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF - 1);

    logic [CW-1:0] cnt_ff;
    logic          tick_ff;

    always_ff @(posedge clk) begin
        if (rst || cnt_ff == LAST) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        tick_ff <= !rst && cnt_ff == LAST;
    end

    assign tick = tick_ff;
endmodule : tpsel_div

// >>> hdl/tpsel_shift.sv
// Strobe, data and clock serial engine, MSB first, sampling input on the rising clock.
`timescale 1ns/100ps
module tpsel_shift import tpsel_pkg::*; #(
    parameter int W = CTL_W
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic tick,
    tpsel_ser_if.eng  s,
    input  wire logic sin,
    output wire logic sclk,
    output wire logic sdata,
    output wire logic sstb
);
    localparam int BW = $clog2(W + 1);

    tpsel_sh_e     st_ff;
    logic [W-1:0]  sh_ff;
    logic [W-1:0]  rx_ff;
    logic [BW-1:0] n_ff;
    logic          sclk_ff;
    logic          sdata_ff;
    logic          done_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= SH_IDLE;
        end else begin
            case (st_ff)
                SH_IDLE:  if (s.start) st_ff <= SH_SHIFT;
                SH_SHIFT: if (tick && sclk_ff && n_ff == BW'(W - 1)) st_ff <= SH_STB;
                SH_STB:   if (tick) st_ff <= SH_IDLE;
                default:  st_ff <= SH_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sh_ff    <= '0;
            rx_ff    <= '0;
            n_ff     <= '0;
            sclk_ff  <= 1'b0;
            sdata_ff <= 1'b0;
        end else if (st_ff == SH_IDLE && s.start) begin
            sh_ff    <= s.tx_word;
            sdata_ff <= s.tx_word[W-1];
            n_ff     <= '0;
        end else if (st_ff == SH_SHIFT && tick) begin
            sclk_ff <= !sclk_ff;
            if (!sclk_ff) begin
                rx_ff <= {rx_ff[W-2:0], sin};
            end else begin
                sh_ff    <= sh_ff << 1;
                sdata_ff <= sh_ff[W-2];
                n_ff     <= n_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        done_ff <= !rst && st_ff == SH_STB && tick;
    end

    assign sclk      = sclk_ff;
    assign sdata     = sdata_ff;
    assign sstb      = (st_ff == SH_STB);
    assign s.busy    = (st_ff != SH_IDLE);
    assign s.done    = done_ff;
    assign s.rx_word = rx_ff;
endmodule : tpsel_shift

// >>> hdl/tpsel_top.sv
// Front-panel selection logic of a transmitter control unit with an AXI4-Lite register slave.
// Contract
// - Eight mode buttons; the lamp of the current mode is lit.
// - Off clears standby and high tension.
// - Standby selects standby and clears off and high tension.
// - High tension is accepted only while standby is selected.
// - Reset commands trip clearing and a tuning sequence.
// - Low power toggles on each press.
// - Mute clears operate and transmit and mutes the transmitter.
// - Operate clears mute and transmit; press-to-talk then keys the transmitter.
// - Transmit clears mute and operate and keys the transmitter.
// - Recall loads stored frequency and mode, leaves transmitter control alone.
// - Check disables panel, stores settings, interrogates, mode lamps show revertive data.
// - Second check press ends check and stores settings again.
// - In disables panel, stores settings, accepts peer or computer settings.
// - Second in press cancels; earlier settings stay in the recall store.
// - Out offers the settings to a peer unit.
// - Eight indicators follow the revertive data.
// - Ancillary port gives a clock, takes serial data, selected by low line.
// - Control and display registers leave on strobe, data and clock lines.
// - Four user inputs are sent; four revertive user outputs are driven.
// - Revertive data never changes transmitter control.
`timescale 1ns/100ps
module tpsel_top import tpsel_pkg::*; #(
    parameter int HALF = HALF_DIV
) (
    input  wire logic              CORE_CLK,
    input  wire logic              RST,
    input  wire logic [7:0]        AWADDR,
    input  wire logic              AWVALID,
    output wire logic              AWREADY,
    input  wire logic [31:0]       WDATA,
    input  wire logic [3:0]        WSTRB,
    input  wire logic              WVALID,
    output wire logic              WREADY,
    output wire logic [1:0]        BRESP,
    output wire logic              BVALID,
    input  wire logic              BREADY,
    input  wire logic [7:0]        ARADDR,
    input  wire logic              ARVALID,
    output wire logic              ARREADY,
    output wire logic [31:0]       RDATA,
    output wire logic [1:0]        RRESP,
    output wire logic              RVALID,
    input  wire logic              RREADY,
    input  wire logic [MODE_N-1:0] BTN_MODE,
    input  wire logic              BTN_OFF,
    input  wire logic              BTN_STANDBY,
    input  wire logic              BTN_HT_ON,
    input  wire logic              BTN_RESET,
    input  wire logic              BTN_LOW_POWER,
    input  wire logic              BTN_MUTE,
    input  wire logic              BTN_OPERATE,
    input  wire logic              BTN_TRANSMIT,
    input  wire logic              BTN_RECALL,
    input  wire logic              BTN_CHECK,
    input  wire logic              BTN_IN,
    input  wire logic              BTN_OUT,
    input  wire logic [FREQ_W-1:0] FREQ_SEL,
    input  wire logic              PRESS_TO_TALK_INPUT,
    input  wire logic              REV_STB,
    input  wire logic [REV_W-1:0]  REV_DATA,
    input  wire logic [3:0]        USER_FN_IN,
    output wire logic [MODE_N-1:0] MODE_LAMP,
    output wire logic [6:0]        TX_LAMP,
    output wire logic [3:0]        STATUS_LAMP,
    output wire logic [7:0]        IND,
    output wire logic [3:0]        USER_FN_REV,
    output wire logic              TX_TRIP_CLR,
    output wire logic              TX_TUNE_START,
    output wire logic              TX_KEY,
    output wire logic              TX_MUTE,
    output wire logic              TX_LOW_POWER,
    output wire logic              INTERROGATE,
    output wire logic              OUT_AVAIL,
    output wire logic              CREG_STB,
    output wire logic              CREG_DATA,
    output wire logic              CREG_CLK,
    output wire logic              DREG_STB,
    output wire logic              DREG_DATA,
    output wire logic              DREG_CLK,
    output wire logic              EXT_CLK,
    input  wire logic              EXT_DATA,
    input  wire logic              EXT_SEL_N
);
    function automatic logic [2:0] oh2idx(input logic [MODE_N-1:0] v);
        oh2idx = 3'h0;
        for (int i = 0; i < MODE_N; i++) begin
            if (v[i]) oh2idx = 3'(i);
        end
    endfunction : oh2idx

    function automatic logic [MODE_N-1:0] idx2oh(input logic [2:0] i);
        idx2oh = MODE_RST << i;
    endfunction : idx2oh

    function automatic logic hit(input logic [7:0] a);
        hit = (a == A_STATE) || (a == A_PEER) || (a == A_RECALL) || (a == A_REVERT);
    endfunction : hit

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    tpsel_stat_e       stat_ff;
    logic [MODE_N-1:0] mode_ff;
    logic [FREQ_W-1:0] freq_ff;
    logic [FREQ_W-1:0] fsel_q_ff;
    logic [FREQ_W-1:0] rc_freq_ff;
    logic [MODE_N-1:0] rc_mode_ff;
    logic [31:0]       peer_ff;
    logic              peer_apl_ff;
    logic [REV_W-1:0]  rev_ff;
    logic              off_ff, stby_ff, ht_ff, lowp_ff, mute_ff, oper_ff, xmit_ff;
    logic              key_ff, rstc_ff, intg_ff;
    logic              pnl_en, ent_chk, ext_chk, ent_in, tick, ext_load;
    logic [6:0]        tx_bits;

    tpsel_ser_if #(.W(CTL_W))  ctl_if ();
    tpsel_ser_if #(.W(FREQ_W)) dsp_if ();
    tpsel_ser_if #(.W(FREQ_W)) ext_if ();

    // Check and in lock the panel; out leaves it live.
    assign pnl_en   = (stat_ff == ST_NORM) || (stat_ff == ST_OUT);
    assign ent_chk  = (stat_ff == ST_NORM) && BTN_CHECK;
    assign ext_chk  = (stat_ff == ST_CHECK) && BTN_CHECK;
    assign ent_in   = (stat_ff == ST_NORM) && BTN_IN && !BTN_CHECK;
    assign tx_bits  = {xmit_ff, oper_ff, mute_ff, lowp_ff, ht_ff, stby_ff, off_ff};

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            stat_ff <= ST_NORM;
        end else begin
            case (stat_ff)
                ST_NORM: begin
                    if (BTN_CHECK) stat_ff <= ST_CHECK;
                    else if (BTN_IN) stat_ff <= ST_IN;
                    else if (BTN_OUT) stat_ff <= ST_OUT;
                end
                ST_CHECK: if (BTN_CHECK) stat_ff <= ST_NORM;
                ST_IN:    if (BTN_IN) stat_ff <= ST_NORM;
                ST_OUT:   if (BTN_OUT) stat_ff <= ST_NORM;
                default:  stat_ff <= ST_NORM;
            endcase
        end
    end

    // Entering check or in, and leaving check, copy the settings into the recall store.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            rc_freq_ff <= '0;
            rc_mode_ff <= MODE_RST;
        end else if (ent_chk || ext_chk || ent_in) begin
            rc_freq_ff <= freq_ff;
            rc_mode_ff <= mode_ff;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        fsel_q_ff <= RST ? '0 : FREQ_SEL;
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            freq_ff <= '0;
            mode_ff <= MODE_RST;
        end else if (stat_ff == ST_IN && peer_apl_ff) begin
            freq_ff <= peer_ff[FREQ_W-1:0];
            mode_ff <= idx2oh(peer_ff[F_MODE +: 3]);
        end else if (pnl_en && BTN_RECALL) begin
            freq_ff <= rc_freq_ff;
            mode_ff <= rc_mode_ff;
        end else if (pnl_en) begin
            if (ext_load) freq_ff <= ext_if.rx_word;
            else if (FREQ_SEL != fsel_q_ff) freq_ff <= FREQ_SEL;
            if (|BTN_MODE) mode_ff <= BTN_MODE & (~BTN_MODE + 8'h01);
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            off_ff  <= 1'b1;
            stby_ff <= 1'b0;
            ht_ff   <= 1'b0;
        end else if (pnl_en) begin
            if (BTN_OFF) begin
                off_ff  <= 1'b1;
                stby_ff <= 1'b0;
                ht_ff   <= 1'b0;
            end else if (BTN_STANDBY) begin
                off_ff  <= 1'b0;
                stby_ff <= 1'b1;
                ht_ff   <= 1'b0;
            end else if (BTN_HT_ON && stby_ff) begin
                ht_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            lowp_ff <= 1'b0;
        end else if (pnl_en && BTN_LOW_POWER) begin
            lowp_ff <= !lowp_ff;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            mute_ff <= 1'b1;
            oper_ff <= 1'b0;
            xmit_ff <= 1'b0;
        end else if (pnl_en && (BTN_MUTE || BTN_OPERATE || BTN_TRANSMIT)) begin
            mute_ff <= BTN_MUTE;
            oper_ff <= !BTN_MUTE && BTN_OPERATE;
            xmit_ff <= !BTN_MUTE && !BTN_OPERATE;
        end
    end

    // Keying depends only on panel selections and press-to-talk, never on revertive data.
    always_ff @(posedge CORE_CLK) begin
        key_ff  <= !RST && (xmit_ff || (oper_ff && PRESS_TO_TALK_INPUT));
        rstc_ff <= !RST && pnl_en && BTN_RESET;
        intg_ff <= !RST && ent_chk;
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            rev_ff <= '0;
        end else if (REV_STB) begin
            rev_ff <= REV_DATA;
        end
    end

    assign MODE_LAMP = (stat_ff == ST_CHECK) ? idx2oh(rev_ff[REV_MODE +: 3]) : mode_ff;
    assign TX_LAMP       = tx_bits;
    assign STATUS_LAMP   = stat_ff;
    assign IND           = rev_ff[7:0];
    assign USER_FN_REV   = rev_ff[REV_UF +: 4];
    assign TX_TRIP_CLR   = rstc_ff;
    assign TX_TUNE_START = rstc_ff;
    assign TX_KEY        = key_ff;
    assign TX_MUTE       = mute_ff;
    assign TX_LOW_POWER  = lowp_ff;
    assign INTERROGATE   = intg_ff;
    assign OUT_AVAIL     = (stat_ff == ST_OUT);

    // Both register streams repeat without pause so the far end always holds fresh data.
    assign ctl_if.start   = 1'b1;
    assign ctl_if.tx_word = {USER_FN_IN, tx_bits, oh2idx(mode_ff)};
    assign dsp_if.start   = 1'b1;
    assign dsp_if.tx_word = freq_ff;
    assign ext_if.start   = !EXT_SEL_N;
    assign ext_if.tx_word = '0;
    assign ext_load       = ext_if.done && !EXT_SEL_N;

    tpsel_div #(.HALF(HALF)) u_div (
        .clk  (CORE_CLK),
        .rst  (RST),
        .tick (tick)
    );

    tpsel_shift #(.W(CTL_W)) u_creg (
        .clk   (CORE_CLK),
        .rst   (RST),
        .tick  (tick),
        .s     (ctl_if.eng),
        .sin   (1'b0),
        .sclk  (CREG_CLK),
        .sdata (CREG_DATA),
        .sstb  (CREG_STB)
    );

    tpsel_shift #(.W(FREQ_W)) u_dreg (
        .clk   (CORE_CLK),
        .rst   (RST),
        .tick  (tick),
        .s     (dsp_if.eng),
        .sin   (1'b0),
        .sclk  (DREG_CLK),
        .sdata (DREG_DATA),
        .sstb  (DREG_STB)
    );

    tpsel_shift #(.W(FREQ_W)) u_ext (
        .clk   (CORE_CLK),
        .rst   (RST),
        .tick  (tick),
        .s     (ext_if.eng),
        .sin   (EXT_DATA),
        .sclk  (EXT_CLK),
        .sdata (),
        .sstb  ()
    );

    logic        aw_ff, w_ff, bv_ff, rv_ff;
    logic [7:0]  awa_ff;
    logic [31:0] wd_ff, rd_ff, nxt_rdata;
    logic [3:0]  ws_ff;
    logic [1:0]  br_ff, rr_ff;
    logic        wr_go;

    assign AWREADY = !aw_ff && !bv_ff;
    assign WREADY  = !w_ff && !bv_ff;
    assign ARREADY = !rv_ff;
    assign wr_go   = aw_ff && w_ff;

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            aw_ff <= 1'b0;
            w_ff  <= 1'b0;
            bv_ff <= 1'b0;
            br_ff <= RESP_OK;
        end else if (wr_go) begin
            aw_ff <= 1'b0;
            w_ff  <= 1'b0;
            bv_ff <= 1'b1;
            br_ff <= hit(awa_ff) ? RESP_OK : RESP_ERR;
        end else begin
            if (AWVALID && AWREADY) aw_ff <= 1'b1;
            if (WVALID && WREADY) w_ff <= 1'b1;
            if (bv_ff && BREADY) bv_ff <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (AWVALID && AWREADY) awa_ff <= AWADDR;
        if (WVALID && WREADY) wd_ff <= WDATA;
        if (WVALID && WREADY) ws_ff <= WSTRB;
    end

    for (genvar b = 0; b < 4; b++) begin : g_peer
        always_ff @(posedge CORE_CLK) begin
            if (RST) begin
                peer_ff[8*b +: 8] <= PEER_RST[8*b +: 8];
            end else if (wr_go && awa_ff == A_PEER && ws_ff[b]) begin
                peer_ff[8*b +: 8] <= wd_ff[8*b +: 8];
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        peer_apl_ff <= !RST && wr_go && awa_ff == A_PEER;
    end

    always_comb begin
        case (ARADDR)
            A_STATE:  nxt_rdata = {12'h000, stat_ff, 1'b0, tx_bits, mode_ff};
            A_PEER:   nxt_rdata = peer_ff;
            A_RECALL: nxt_rdata = {5'h00, oh2idx(rc_mode_ff), rc_freq_ff};
            A_REVERT: nxt_rdata = {16'h0000, rev_ff};
            default:  nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            rv_ff <= 1'b0;
            rd_ff <= '0;
            rr_ff <= RESP_OK;
        end else if (ARVALID && ARREADY) begin
            rv_ff <= 1'b1;
            rd_ff <= nxt_rdata;
            rr_ff <= hit(ARADDR) ? RESP_OK : RESP_ERR;
        end else if (RREADY) begin
            rv_ff <= 1'b0;
        end
    end

    assign BVALID = bv_ff;
    assign BRESP  = br_ff;
    assign RVALID = rv_ff;
    assign RDATA  = rd_ff;
    assign RRESP  = rr_ff;

    sequence s_chk_press;
        stat_ff == ST_NORM && BTN_CHECK;
    endsequence

    sequence s_chk_enter;
        INTERROGATE && stat_ff == ST_CHECK && !pnl_en && rc_freq_ff == $past(freq_ff);
    endsequence

    chk_mode_one_hot: assert property ($onehot(mode_ff) && $onehot(MODE_LAMP))
        else $error("mode selection not one-hot");
    chk_off_clears: assert property (pnl_en && BTN_OFF |=> off_ff && !stby_ff && !ht_ff)
        else $error("off did not clear standby and high tension");
    chk_stby_select: assert property (pnl_en && BTN_STANDBY && !BTN_OFF
        |=> stby_ff && !off_ff && !ht_ff)
        else $error("standby selection wrong");
    chk_ht_gate: assert property ($rose(ht_ff) |-> $past(stby_ff))
        else $error("high tension rose without standby");
    chk_reset_pulse: assert property (pnl_en && BTN_RESET
        |=> TX_TRIP_CLR && TX_TUNE_START ##1 !TX_TRIP_CLR || $past(BTN_RESET))
        else $error("reset command pulse wrong");
    chk_low_toggle: assert property (pnl_en && BTN_LOW_POWER |=> lowp_ff != $past(lowp_ff))
        else $error("low power did not toggle");
    chk_mute_sel: assert property (pnl_en && BTN_MUTE
        |=> mute_ff && !oper_ff && !xmit_ff ##1 !TX_KEY)
        else $error("mute did not clear keying");
    chk_talk_key: assert property (oper_ff && PRESS_TO_TALK_INPUT |=> TX_KEY)
        else $error("press-to-talk did not key");
    chk_xmit_key: assert property (pnl_en && BTN_TRANSMIT && !BTN_MUTE && !BTN_OPERATE
        |=> xmit_ff && !mute_ff ##1 TX_KEY)
        else $error("transmit did not key");
    chk_recall_load: assert property (pnl_en && BTN_RECALL && !BTN_OFF && !BTN_STANDBY
        && !BTN_HT_ON && !BTN_LOW_POWER && !BTN_MUTE && !BTN_OPERATE && !BTN_TRANSMIT
        |=> freq_ff == $past(rc_freq_ff) && $stable(tx_bits))
        else $error("recall load wrong");
    chk_check_entry: assert property (s_chk_press |=> s_chk_enter)
        else $error("check entry sequence wrong");
    chk_in_entry: assert property (ent_in |=> stat_ff == ST_IN && rc_freq_ff == $past(freq_ff))
        else $error("in entry wrong");
    chk_rev_ind: assert property (REV_STB |=> IND == $past(REV_DATA[7:0]))
        else $error("indicators do not follow revertive data");
    chk_rev_isolate: assert property (!pnl_en |=> $stable(tx_bits))
        else $error("transmitter control moved while panel locked");
endmodule : tpsel_top

// >>> verification/tpsel_rev_model.sv
// Revertive data source standing in for the remote transmitter.
`timescale 1ns/100ps
module tpsel_rev_model (
    input  wire logic        clk,
    input  wire logic        send,
    input  wire logic [15:0] word,
    output logic             stb,
    output logic [15:0]      data
);
    initial begin
        stb = 1'b0;
        data = 16'h0;
    end
    // Outside a strobe the data lines toggle so stale values are never captured.
    always @(posedge clk) begin
        stb <= send;
        data <= send ? word : ~data;
    end
endmodule : tpsel_rev_model

// >>> verification/testbench.sv
// Self-checking bench for the transmitter panel selection block.
`timescale 1ns/100ps
module testbench import tpsel_pkg::*;;
    logic        clk = 0, rst = 1, talk = 0, send = 0, arv = 0, rrdy = 0, awv = 0, wv = 0, brdy = 0;
    logic [7:0]  ara = 0, awa = 0;
    logic [31:0] wd = 0, rd_d;
    logic [19:0] btn = 0;
    logic [23:0] freq = 0;
    logic [15:0] word = 0, rev_d;
    logic [1:0]  rr;
    logic        rev_s;
    int          num_errors = 0, total_checks = 0;
    wire logic [7:0]  ml, ind;
    wire logic [6:0]  txl;
    wire logic [3:0]  stl, ufr;
    wire logic [31:0] rdata;
    wire logic [1:0]  rresp, bresp;
    wire logic        arrdy, rvalid, awrdy, wrdy, bvalid, trip, tune, key, mute, lowp, intg;
    wire logic        oa, cstb, cdat, cclk;
    always #2.5 clk = ~clk;
    tpsel_rev_model i_rev (.clk(clk), .send(send), .word(word), .stb(rev_s), .data(rev_d));
    tpsel_top #(.HALF(2)) i_dut (.CORE_CLK(clk), .RST(rst), .AWADDR(awa), .AWVALID(awv),
        .AWREADY(awrdy), .WDATA(wd), .WSTRB(4'hf), .WVALID(wv), .WREADY(wrdy), .BRESP(bresp),
        .BVALID(bvalid), .BREADY(brdy), .ARADDR(ara), .ARVALID(arv), .ARREADY(arrdy),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rrdy), .BTN_MODE(btn[7:0]),
        .BTN_OFF(btn[8]), .BTN_STANDBY(btn[9]), .BTN_HT_ON(btn[10]), .BTN_RESET(btn[11]),
        .BTN_LOW_POWER(btn[12]), .BTN_MUTE(btn[13]), .BTN_OPERATE(btn[14]),
        .BTN_TRANSMIT(btn[15]), .BTN_RECALL(btn[16]), .BTN_CHECK(btn[17]), .BTN_IN(btn[18]),
        .BTN_OUT(btn[19]), .FREQ_SEL(freq), .PRESS_TO_TALK_INPUT(talk), .REV_STB(rev_s),
        .REV_DATA(rev_d), .USER_FN_IN(4'h5), .MODE_LAMP(ml), .TX_LAMP(txl), .STATUS_LAMP(stl),
        .IND(ind), .USER_FN_REV(ufr), .TX_TRIP_CLR(trip), .TX_TUNE_START(tune), .TX_KEY(key),
        .TX_MUTE(mute), .TX_LOW_POWER(lowp), .INTERROGATE(intg), .OUT_AVAIL(oa),
        .CREG_STB(cstb), .CREG_DATA(cdat), .CREG_CLK(cclk), .DREG_STB(), .DREG_DATA(),
        .DREG_CLK(), .EXT_CLK(),
        .EXT_DATA(1'b0), .EXT_SEL_N(1'b1));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic hit(input int i);
        @(posedge clk);
        btn[i] <= 1'b1;
        @(posedge clk);
        btn[i] <= 1'b0;
        @(negedge clk);
    endtask : hit
    task automatic press(input int i);
        hit(i);
        repeat (2) @(negedge clk);
    endtask : press
    task automatic rd(input logic [7:0] a);
        bit ok;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rrdy <= 1'b1;
        do begin
            @(negedge clk);
            ok = arrdy;
            @(posedge clk);
        end while (!ok);
        arv <= 1'b0;
        do begin
            @(negedge clk);
            ok = rvalid;
            rd_d = rdata;
            rr = rresp;
            @(posedge clk);
        end while (!ok);
        rrdy <= 1'b0;
        @(negedge clk);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit ta, tw, ok;
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        do begin
            @(negedge clk);
            ta = awv & awrdy;
            tw = wv & wrdy;
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end while ((awv && !ta) || (wv && !tw));
        do begin
            @(negedge clk);
            ok = bvalid;
            rr = bresp;
            @(posedge clk);
        end while (!ok);
        brdy <= 1'b0;
        @(negedge clk);
    endtask : wr
    task automatic t_regs;
        wr(8'h10, 32'h1);
        chk(rr, RESP_ERR);
        rd(A_STATE);
        chk(rd_d, 32'h0001_1101);
        chk(rr, RESP_OK);
        rd(8'h10);
        chk(rr, RESP_ERR);
        $display("regs end");
    endtask : t_regs
    task automatic t_mode;
        for (int i = 0; i < 8; i++) begin
            press(i);
            chk(ml, 8'h1 << i);
        end
        $display("mode end");
    endtask : t_mode
    task automatic t_ctl;
        press(10);
        chk(txl, 7'h11);
        press(9);
        chk(txl, 7'h12);
        press(10);
        chk(txl, 7'h16);
        press(8);
        chk(txl, 7'h11);
        press(12);
        chk({txl, lowp}, {7'h19, 1'b1});
        press(12);
        chk({txl, lowp}, {7'h11, 1'b0});
        hit(11);
        chk({trip, tune}, 2'h3);
        @(negedge clk);
        chk({trip, tune}, 2'h0);
        $display("ctl end");
    endtask : t_ctl
    task automatic t_tx;
        press(14);
        chk({txl, key, mute}, {7'h21, 2'h0});
        @(posedge clk) talk <= 1'b1;
        repeat (3) @(negedge clk);
        chk(key, 1'b1);
        @(posedge clk) talk <= 1'b0;
        press(15);
        chk({txl, key, mute}, {7'h41, 2'h2});
        press(13);
        chk({txl, key, mute}, {7'h11, 2'h1});
        $display("tx end");
    endtask : t_tx
    task automatic t_check;
        hit(17);
        chk({intg, stl}, {1'b1, 4'h2});
        @(posedge clk);
        word <= 16'h3ca5;
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        repeat (3) @(negedge clk);
        chk({ind, ufr, ml, txl}, {8'ha5, 4'hc, 8'h08, 7'h11});
        press(0);
        chk(ml, 8'h08);
        press(17);
        chk({stl, ml}, {4'h1, 8'h80});
        rd(A_RECALL);
        chk(rd_d, 32'h0712_3456);
        press(0);
        press(16);
        chk({ml, txl}, {8'h80, 7'h11});
        $display("check end");
    endtask : t_check
    task automatic t_in;
        press(18);
        wr(A_PEER, 32'h0200_0abc);
        chk({stl, ml, rr}, {4'h4, 8'h04, RESP_OK});
        press(18);
        press(16);
        chk({stl, ml}, {4'h1, 8'h80});
        press(19);
        chk({stl, oa}, {4'h8, 1'b1});
        press(19);
        $display("in end");
    endtask : t_in
    task automatic t_ser;
        logic [13:0] w  = '0;
        logic        pc = 1'b0;
        wait (cstb);
        wait (!cstb);
        do begin
            @(negedge clk);
            if (cclk && !pc) w = {w[12:0], cdat};
            pc = cclk;
        end while (!cstb);
        chk(w, {4'h5, 7'h11, 3'h7});
        $display("ser end");
    endtask : t_ser
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        end_sim();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        freq <= 24'h123456;
        t_regs();
        t_mode();
        t_ctl();
        t_tx();
        t_check();
        t_in();
        t_ser();
        end_sim();
    end
endmodule : testbench
